// file: tb/gpb_pins.sv
// Purpose: Pin-side model resolving each pad level from drivers and outside world
// Assumes: Outside values held steady by the bench until reads complete
// Notes: A driven first-port pin can be pulled low from outside to model contention
`timescale 1ns/1ns
`default_nettype none
module gpb_pins
  import gpb_pkg::*;
(
  input  wire gpb_pkg::gpb_drive_type drive1,   // First port drivers
  input  wire gpb_pkg::gpb_drive_type drive2,   // Second port drivers
  input  wire logic [5:0]             ext1,     // Outside level, first port
  input  wire logic [5:0]             ext2,     // Outside level, second port
  input  wire logic [5:0]             hold_low, // Outside pull-down on first port
  output logic [5:0]                  pin1,     // First port pad levels
  output logic [5:0]                  pin2      // Second port pad levels
);
  // On the first port, the outside pull-down wins low even where the port drives high
  assign pin1 = (~drive1.oe_n & drive1.level & ~hold_low) | (drive1.oe_n & ext1);
  assign pin2 = (~drive2.oe_n & drive2.level) | (drive2.oe_n & ext2);
endmodule : gpb_pins
`default_nettype wire

// file: tb/gpb_port_tb_top.sv
// Purpose: Directed register-level checks of the two-port block
// Assumes: One request per cycle, answers one cycle later
// Notes: Inputs change 2 ns after each rising edge
`timescale 1ns/1ns
`default_nettype none
module gpb_port_tb_top;
  import gpb_pkg::*;
  logic          clk = 1'b0;
  logic          sys_rst = 1'b1;
  logic          por_rst = 1'b1;
  logic          wake_cause = 1'b0;
  gpb_req_type   req = '0;
  logic [5:0]    claim1 = 6'h00;
  logic [5:0]    claim2 = 6'h00;
  logic [5:0]    ext1 = 6'h3F;
  logic [5:0]    ext2 = 6'h3F;
  logic [5:0]    hold_low = 6'h01;
  logic [5:0]    pin1;
  logic [5:0]    pin2;
  gpb_drive_type drive1;
  gpb_drive_type drive2;
  logic [7:0]    rd_data;
  logic [7:0]    option_out;
  logic          wake_flag;
  int            failures = 0;
  int            checks_done = 0;
  gpb_port dut (.clk(clk), .sys_rst(sys_rst), .por_rst(por_rst), .wake_cause(wake_cause), .req(req),
    .alt_claim1(claim1), .alt_claim2(claim2), .pin_in1(pin1), .pin_in2(pin2), .drive1(drive1),
    .drive2(drive2), .rd_data(rd_data), .option_out(option_out), .wake_flag(wake_flag));
  gpb_pins pins (.drive1(drive1), .drive2(drive2), .ext1(ext1), .ext2(ext2), .hold_low(hold_low),
    .pin1(pin1), .pin2(pin2));
  initial
  begin
    forever #10 clk = ~clk;
  end
  task cyc;
    @(posedge clk);
    #2;
  endtask : cyc
  // Enables are wr, rd, dir, opt from high to low
  task op(input logic [3:0] en, input logic [7:0] a, input logic [7:0] d);
    req = {en, a, d};
    cyc();
    req = '0;
    cyc();
  endtask : op
  task chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task do_rst(input logic por, input logic wake);
    sys_rst = 1'b1;
    por_rst = por;
    wake_cause = wake;
    repeat (5) cyc();
    sys_rst = 1'b0;
    por_rst = 1'b0;
    wake_cause = 1'b0;
  endtask : do_rst
  task end_of_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (2000) @(posedge clk);
    failures++;
    end_of_test();
  end
  initial
  begin
    do_rst(1'b1, 1'b0);
    chk({2'h0, drive1.oe_n}, 8'h3F);
    chk({2'h0, drive2.oe_n}, 8'h3F);
    chk(option_out, 8'hFF);
    op(4'h8, 8'h06, 8'h15);
    op(4'h8, 8'h07, 8'hEA);
    chk({2'h0, drive1.level}, 8'h15);
    op(4'h2, 8'h06, 8'hC0);
    chk({2'h0, drive1.oe_n}, 8'h08);
    op(4'h2, 8'h07, 8'h00);
    chk({2'h0, drive2.oe_n}, 8'h20);
    op(4'h1, 8'h00, 8'hDF);
    chk({2'h0, drive2.oe_n}, 8'h00);
    op(4'h4, 8'h06, 8'h00);
    chk(rd_data, 8'h1C);
    ext1 = 6'h00;
    op(4'h4, 8'h06, 8'h00);
    chk(rd_data, 8'h14);
    op(4'h4, 8'h07, 8'h00);
    chk(rd_data, 8'h2A);
    claim2 = 6'h01;
    cyc();
    chk({2'h0, drive2.oe_n}, 8'h01);
    op(4'h4, 8'h07, 8'h00);
    chk(rd_data, 8'h2A);
    op(4'h2, 8'h06, 8'h15);
    chk({2'h0, drive1.oe_n}, 8'h1D);
    chk({2'h0, drive1.level}, 8'h15);
    op(4'h4, 8'h05, 8'h00);
    chk(rd_data, 8'h00);
    do_rst(1'b0, 1'b1);
    chk({2'h0, drive1.oe_n}, 8'h3F);
    chk({2'h0, drive1.level}, 8'h15);
    op(4'h4, 8'h03, 8'h00);
    chk(rd_data, 8'h80);
    do_rst(1'b1, 1'b0);
    chk({2'h0, drive1.level}, 8'h00);
    chk({7'h00, wake_flag}, 8'h00);
    end_of_test();
  end
endmodule : gpb_port_tb_top
`default_nettype wire

// file: verilog/gpb_pkg.sv
// Purpose: Constants and carriers for the six-bit general-purpose port block
// Assumes: Core presents one instruction-level request per cycle
// Notes: Register offsets are data-memory addresses seen by the core
// Behaviour
// - Second port register is 8 bits; bits 5..0 are pins, 7..6 read zero.
// - Load-direction instruction copies working register into named port's direction register.
// - Direction bit one disables the pin's output driver.
// - Direction bit zero drives pin from its output data latch.
// - First port bit 3 is input only; never driven.
// - Timer clock source setting in option register claims timer clock pin.
// - Port reads return pin levels, not latch contents.
// - Direction registers are write-only and reset to all ones.
// - Inputs are not latched; read samples pins at read instant.
// - Output latches hold until software rewrites the port register or a power-on reset clears them.
// - Each pin's direction is set independently by its own bit.
// - Status bit 7 set after wake-on-change reset, cleared otherwise.
// - Enabled alternate functions override direction bit by fixed priority.
// - Pins claimed by an alternate function read as zero.
package gpb_pkg;

  localparam int unsigned PORT_WIDTH      = 6;
  localparam logic [7:0]  ADDR_STATUS     = 8'h03;
  localparam logic [7:0]  ADDR_PORT1      = 8'h06;
  localparam logic [7:0]  ADDR_PORT2      = 8'h07;
  localparam logic [5:0]  DIR_RESET       = 6'h3F;
  localparam logic [7:0]  OPTION_RESET    = 8'hFF;
  localparam logic [5:0]  LATCH_POR_VALUE = 6'h00;
  localparam int unsigned OPT_TCS_BIT     = 5;
  localparam int unsigned STATUS_WAKE_BIT = 7;
  localparam int unsigned INPUT_ONLY_BIT  = 3;
  localparam int unsigned TIMER_PIN_BIT   = 5;

  // One core request per cycle; at most one enable set
  typedef struct packed {
    logic       wr_en;     // Data write to addr
    logic       rd_en;     // Data read from addr
    logic       dir_en;    // Load-direction instruction, addr names port
    logic       opt_en;    // Option load instruction
    logic [7:0] addr;      // File address
    logic [7:0] wdata;     // Working register value
  } gpb_req_type;

  typedef struct packed {
    logic [5:0] level;     // Driven level
    logic [5:0] oe_n;      // Low while driving
  } gpb_drive_type;

endpackage : gpb_pkg

// file: verilog/gpb_port.sv
// Purpose: Two six-bit ports with direction, option override and pin reads
// Assumes: Inputs synchronous to clk; alternate claims come from configuration logic
// Notes: Read data registered one cycle after the read request
`timescale 1ns/1ns
`default_nettype none
module gpb_port
  import gpb_pkg::*;
#(
  parameter int unsigned W = gpb_pkg::PORT_WIDTH
)(
  input  wire logic                 clk,         // 50 MHz core clock
  input  wire logic                 sys_rst,     // Synchronous reset, active high
  input  wire logic                 por_rst,     // Qualifies sys_rst as power-on
  input  wire logic                 wake_cause,  // Reset caused by pin change wake
  input  wire gpb_pkg::gpb_req_type req,         // Core request
  input  wire logic [W-1:0]         alt_claim1,  // First port alternate claims
  input  wire logic [W-1:0]         alt_claim2,  // Second port alternate claims
  input  wire logic [W-1:0]         pin_in1,     // First port pin levels
  input  wire logic [W-1:0]         pin_in2,     // Second port pin levels
  output var gpb_pkg::gpb_drive_type drive1,     // First port drivers
  output var gpb_pkg::gpb_drive_type drive2,     // Second port drivers
  output logic [7:0]                rd_data,     // Registered read data
  output logic [7:0]                option_out,  // Option settings to timer logic
  output logic                      wake_flag    // Status bit 7
);
  import gpb_pkg::*;

  logic [W-1:0] dir1;
  logic [W-1:0] dir2;
  logic [W-1:0] latch1;
  logic [W-1:0] latch2;
  logic [7:0]   option;
  logic [W-1:0] next_dir1;
  logic [W-1:0] next_dir2;
  logic [W-1:0] next_latch1;
  logic [W-1:0] next_latch2;
  logic [7:0]   next_option;
  logic [7:0]   next_rd_data;
  logic         next_wake_flag;
  logic [W-1:0] claim1;
  logic [W-1:0] claim2;

  // Pins visible to software: claimed pins read zero
  function automatic logic [7:0] port_view(input logic [W-1:0] pins, input logic [W-1:0] claim);
    port_view = {2'h0, pins & ~claim};
  endfunction : port_view

  // Final claim per pin after alternate functions and option override
  always_comb
  begin
    claim1 = alt_claim1;
    claim2 = alt_claim2;
    claim2[TIMER_PIN_BIT] = alt_claim2[TIMER_PIN_BIT] | option[OPT_TCS_BIT];
  end

  // Direction, option and latch state
  always_comb
  begin
    next_dir1   = dir1;
    next_dir2   = dir2;
    next_option = option;
    next_latch1 = latch1;
    next_latch2 = latch2;
    if (sys_rst)
    begin
      next_dir1   = DIR_RESET;
      next_dir2   = DIR_RESET;
      next_option = OPTION_RESET;
      // Latches survive warm resets; power-on gives a defined zero
      if (por_rst)
      begin
        next_latch1 = LATCH_POR_VALUE;
        next_latch2 = LATCH_POR_VALUE;
      end
    end
    else
    begin
      if (req.dir_en && req.addr == ADDR_PORT1)
        next_dir1 = req.wdata[W-1:0];
      if (req.dir_en && req.addr == ADDR_PORT2)
        next_dir2 = req.wdata[W-1:0];
      if (req.opt_en)
        next_option = req.wdata;
      if (req.wr_en && req.addr == ADDR_PORT1)
        next_latch1 = req.wdata[W-1:0];
      if (req.wr_en && req.addr == ADDR_PORT2)
        next_latch2 = req.wdata[W-1:0];
    end
  end

  always_ff @(posedge clk)
  begin
    dir1   <= next_dir1;
    dir2   <= next_dir2;
    option <= next_option;
    latch1 <= next_latch1;
    latch2 <= next_latch2;
  end

  // Read path and wake status
  always_comb
  begin
    next_rd_data   = rd_data;
    next_wake_flag = wake_flag;
    if (sys_rst)
    begin
      next_rd_data   = 8'h00;
      next_wake_flag = wake_cause;
    end
    else if (req.rd_en)
    begin
      // Pins sampled at the read instant, never held between reads
      case (req.addr)
        ADDR_PORT1:  next_rd_data = port_view(pin_in1, claim1);
        ADDR_PORT2:  next_rd_data = port_view(pin_in2, claim2);
        ADDR_STATUS: next_rd_data = {wake_flag, 7'h00};
        default:     next_rd_data = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    rd_data   <= next_rd_data;
    wake_flag <= next_wake_flag;
  end

  // Pin drivers, each bit on its own direction bit and claim; first port bit 3 never driven
  always_comb
  begin
    drive1.level = latch1;
    drive2.level = latch2;
    drive1.oe_n  = dir1 | claim1;
    drive2.oe_n  = dir2 | claim2;
    drive1.oe_n[INPUT_ONLY_BIT] = 1'b1;
  end

  assign option_out = option;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Reset checks below opt back in with their own disable

  // Status reads carry the wake flag in bit 7, so only port reads count
  sequence s_port_read;
    req.rd_en && (req.addr == ADDR_PORT1 || req.addr == ADDR_PORT2);
  endsequence
  property p_high_bits_zero;
    s_port_read |=> rd_data[7:6] == 2'h0;
  endproperty
  a_high_bits_zero: assert property (p_high_bits_zero) else $error("port high bits not zero");

  sequence s_dir_load2;
    req.dir_en && req.addr == ADDR_PORT2;
  endsequence
  property p_dir_load2;
    s_dir_load2 |=> dir2 == $past(req.wdata[5:0]);
  endproperty
  a_dir_load2: assert property (p_dir_load2) else $error("direction load lost");

  sequence s_dir_load1;
    req.dir_en && req.addr == ADDR_PORT1;
  endsequence
  property p_dir_load1;
    s_dir_load1 |=> dir1 == $past(req.wdata[W-1:0]);
  endproperty
  a_dir_load1: assert property (p_dir_load1) else $error("first port direction load lost");

  property p_dir_hold2;
    !(req.dir_en && req.addr == ADDR_PORT2) |=> $stable(dir2);
  endproperty
  a_dir_hold2: assert property (p_dir_hold2) else $error("second port direction changed without load");

  property p_dir_hold1;
    !(req.dir_en && req.addr == ADDR_PORT1) |=> $stable(dir1);
  endproperty
  a_dir_hold1: assert property (p_dir_hold1) else $error("direction changed without load");

  property p_hiz;
    ((dir1 & ~drive1.oe_n) == '0) && ((dir2 & ~drive2.oe_n) == '0);
  endproperty
  a_hiz: assert property (p_hiz) else $error("driver on while direction is one");

  property p_drive;
    (!dir1[1] && !claim1[1]) |-> (!drive1.oe_n[1] && drive1.level[1] == latch1[1]);
  endproperty
  a_drive: assert property (p_drive) else $error("driver off while output selected");

  property p_drive_all;
    ((~dir2 & ~claim2 & drive2.oe_n) == '0) && drive1.level == latch1 && drive2.level == latch2;
  endproperty
  a_drive_all: assert property (p_drive_all) else $error("second port driver off while output selected");

  property p_second_bit3;
    (!dir2[INPUT_ONLY_BIT] && !claim2[INPUT_ONLY_BIT]) |-> !drive2.oe_n[INPUT_ONLY_BIT];
  endproperty
  a_second_bit3: assert property (p_second_bit3) else $error("second port bit 3 not drivable");

  property p_input_only;
    drive1.oe_n[INPUT_ONLY_BIT];
  endproperty
  a_input_only: assert property (p_input_only) else $error("input-only pin driven");

  property p_timer_claim;
    option[OPT_TCS_BIT] |-> drive2.oe_n[TIMER_PIN_BIT];
  endproperty
  a_timer_claim: assert property (p_timer_claim) else $error("timer pin driven under option");

  // Clearing the option bit hands the timer pin back to its direction bit
  property p_timer_free;
    (!option[OPT_TCS_BIT] && !alt_claim2[TIMER_PIN_BIT] && !dir2[TIMER_PIN_BIT]) |-> !drive2.oe_n[TIMER_PIN_BIT];
  endproperty
  a_timer_free: assert property (p_timer_free) else $error("timer pin not released by option");

  property p_opt_load;
    req.opt_en |=> option == $past(req.wdata);
  endproperty
  a_opt_load: assert property (p_opt_load) else $error("option load lost");

  sequence s_read1;
    req.rd_en && req.addr == ADDR_PORT1;
  endsequence
  property p_read1;
    s_read1 |=> rd_data == {2'h0, $past(pin_in1) & ~$past(claim1)};
  endproperty
  a_read1: assert property (p_read1) else $error("port read not pin levels");

  property p_claim_read1;
    s_read1 |=> (rd_data[W-1:0] & $past(claim1)) == '0;
  endproperty
  a_claim_read1: assert property (p_claim_read1) else $error("claimed pin read not zero");

  sequence s_read2;
    req.rd_en && req.addr == ADDR_PORT2;
  endsequence
  property p_read2;
    s_read2 |=> rd_data == {2'h0, $past(pin_in2) & ~$past(claim2)};
  endproperty
  a_read2: assert property (p_read2) else $error("second port read not pin levels");

  sequence s_status_read;
    req.rd_en && req.addr == ADDR_STATUS;
  endsequence
  property p_status_read;
    s_status_read |=> rd_data == {$past(wake_flag), 7'h00};
  endproperty
  a_status_read: assert property (p_status_read) else $error("status read wrong");

  // A stale read value must not follow the pins
  property p_rd_hold;
    !req.rd_en |=> $stable(rd_data);
  endproperty
  a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");

  property p_reset_dir;
    disable iff (1'b0) sys_rst |=> (dir1 == DIR_RESET && dir2 == DIR_RESET && option == OPTION_RESET);
  endproperty
  a_reset_dir: assert property (p_reset_dir) else $error("direction not set by reset");

  property p_latch_hold;
    disable iff (1'b0) !(req.wr_en && req.addr == ADDR_PORT2) && !(sys_rst && por_rst) |=> $stable(latch2);
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("output latch changed");

  property p_latch_hold1;
    disable iff (1'b0) !(req.wr_en && req.addr == ADDR_PORT1) && !(sys_rst && por_rst) |=> $stable(latch1);
  endproperty
  a_latch_hold1: assert property (p_latch_hold1) else $error("first port latch changed");

  sequence s_write1;
    req.wr_en && req.addr == ADDR_PORT1;
  endsequence
  property p_latch_load1;
    s_write1 |=> drive1.level == $past(req.wdata[W-1:0]);
  endproperty
  a_latch_load1: assert property (p_latch_load1) else $error("first port write lost");

  // Warm resets keep latches, so only power-on is checked here
  property p_por_clear;
    disable iff (1'b0) (sys_rst && por_rst) |=> (latch1 == LATCH_POR_VALUE && latch2 == LATCH_POR_VALUE);
  endproperty
  a_por_clear: assert property (p_por_clear) else $error("latch not cleared at power-on");

  property p_wake;
    disable iff (1'b0) sys_rst |=> wake_flag == $past(wake_cause);
  endproperty
  a_wake: assert property (p_wake) else $error("wake flag wrong after reset");

  property p_wake_hold;
    !sys_rst |=> $stable(wake_flag);
  endproperty
  a_wake_hold: assert property (p_wake_hold) else $error("wake flag changed outside reset");

  property p_claim;
    (alt_claim1[2] && !dir1[2]) |-> drive1.oe_n[2];
  endproperty
  a_claim: assert property (p_claim) else $error("claimed pin still driven");

  property p_claim_all;
    ((claim1 & ~drive1.oe_n) == '0) && ((claim2 & ~drive2.oe_n) == '0);
  endproperty
  a_claim_all: assert property (p_claim_all) else $error("alternate function pin driven");

endmodule : gpb_port
`default_nettype wire
